// >>> rtl/flash_array_mem.sv
// Flash cell array: data words then the information row.
// Assumes one write at a time; both read ports are registered.
`timescale 1ns/1ps
module flash_array_mem (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  host_addr,
  output logic      [15:0] host_rdata,
  input  wire logic [8:0]  seq_addr,
  output logic      [15:0] seq_rdata,
  input  wire logic        wr_en,
  input  wire logic [8:0]  wr_addr,
  input  wire logic [15:0] wr_data
);
  logic [15:0] cells [flash_seq_pkg::MEM_WORDS];

  // Cells come up erased
  initial begin
    for (int i = 0; i < flash_seq_pkg::MEM_WORDS; i++) begin
      cells[i] = flash_seq_pkg::ERASED;
    end
  end

  // R2 - single cycle read
  always_ff @(posedge ref_clk) begin
    host_rdata <= cells[{1'b0, host_addr}];
    seq_rdata  <= cells[seq_addr];
  end

  // Plain always: the erased power-up image also writes the cells
  always @(posedge ref_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end
endmodule : flash_array_mem

// >>> rtl/flash_cmd_seq.sv
// Embedded flash command sequencer: array read port, register port,
// two-stage command queue and command engine.
// Assumes program-bus and data-bus strobes are synchronous single-cycle pulses.
//
// Contract
// R1 - Array sits on program bus; registers sit on data bus.
// R2 - Array reads return data with no wait states.
// R3 - Host programs by array write, program code, then launch.
// R4 - Command, address and data queue two deep.
// R5 - Signature commands never queue nor let others queue behind.
// R6 - Launch accepted only when buffer empty; otherwise access error.
// R7 - Completion flag plus interrupts for buffer-empty and completion when enabled.
// R8 - Erased cells read ones; programming only clears bits.
// R9 - Host erases by array write, erase code, then launch.
// R10 - Page erase clears the page holding the latched address.
// R11 - Mass erase clears whole array; address and data ignored.
// R12 - Erase verify sets blank bit only when all words read ones.
// R13 - Data signature covers latched-data words from latched address.
// R14 - Program writes one word only when its sector is unprotected.
// R15 - Page erase only when that page is unprotected.
// R16 - Mass erase only when no protection bit is set.
// R17 - Info-row signature covers row one minus its last word.
// R18 - Factory signature register loads from the array at reset.
// R19 - Trim register shows trim in low ten bits.
// R20 - Invalid command code sets access error and aborts sequence.
// R21 - Launch clears completion; buffer-empty returns once buffer frees.
// R22 - Completion flag sets when the operation finishes; here only when no command waits in the buffer.
// R23 - Signature result holds until next signature completes or reset.
// R24 - Exactly one address/data pair latched per sequence.
`timescale 1ns/1ps
module flash_cmd_seq (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  prog_addr,
  input  wire logic        prog_wr,
  input  wire logic [15:0] prog_wdata,
  output logic      [15:0] prog_rdata,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic [7:0]  sector_protect,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  flash_seq_pkg::front_state_t front_q, front_d;
  flash_seq_pkg::exec_state_t  exec_q, exec_d;
  flash_seq_pkg::cmd_entry_t   entry_q, entry_d, buf_q, buf_d, ex_q, ex_d;
  logic        buf_full_q, buf_full_d;
  logic        bempty_q, bempty_d, cdone_q, cdone_d, aerr_q, aerr_d;
  logic        pviol_q, pviol_d, blank_q, blank_d;
  logic        cbeie_q, cbeie_d, ccie_q, ccie_d, irq_d;
  logic [15:0] rdata_d;
  logic [8:0]  ptr_q, ptr_d;
  logic [16:0] rem_q, rem_d;
  logic        rvalid_q, rvalid_d, allone_q, allone_d;
  logic [15:0] data_q, data_d, fsig_q, fsig_d;
  logic [9:0]  trim_q, trim_d;
  logic        acc_set, pv_set, launch, xfer, exec_done, boot_done, blank_ok;
  logic        misr_clr, wr_en;
  logic [15:0] wr_data, seq_rdata, misr_sig;
  logic        wr_stat, wr_cmd, wr_cfg, prot_hit;

  // R1 - separate buses
  assign wr_stat  = reg_wr && (reg_addr == flash_seq_pkg::STAT_OFS);
  assign wr_cmd   = reg_wr && (reg_addr == flash_seq_pkg::CMD_OFS);
  assign wr_cfg   = reg_wr && (reg_addr == flash_seq_pkg::CFG_OFS);
  assign xfer     = buf_full_q && (exec_q == flash_seq_pkg::E_IDLE);

  // R14 - sector protection
  assign prot_hit =
    (((entry_q.cmd == flash_seq_pkg::CMD_PROGRAM) ||
      (entry_q.cmd == flash_seq_pkg::CMD_PAGE_ERASE)) &&
     sector_protect[entry_q.addr[flash_seq_pkg::AW-1:flash_seq_pkg::PAGE_BITS]]) ||
    // R16 - any protection blocks mass erase
    ((entry_q.cmd == flash_seq_pkg::CMD_MASS_ERASE) && (|sector_protect));

  flash_array_mem u_mem (
    .ref_clk    (ref_clk),
    .host_addr  (prog_addr),
    .host_rdata (prog_rdata),
    .seq_addr   (ptr_q),
    .seq_rdata  (seq_rdata),
    .wr_en      (wr_en),
    .wr_addr    (ptr_q),
    .wr_data    (wr_data)
  );

  sig_misr u_misr (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clr     (misr_clr),
    .en      (rvalid_q && flash_seq_pkg::is_sig(ex_q.cmd)),
    .din     (seq_rdata),
    .sig_q   (misr_sig)
  );

  // ----------------------------------------------------------------
  // Command write sequence, queue and status flags
  // ----------------------------------------------------------------
  always_comb begin
    front_d    = front_q;
    entry_d    = entry_q;
    buf_d      = buf_q;
    buf_full_d = buf_full_q;
    bempty_d   = bempty_q;
    cdone_d    = cdone_q;
    aerr_d     = aerr_q;
    pviol_d    = pviol_q;
    blank_d    = blank_q;
    cbeie_d    = cbeie_q;
    ccie_d     = ccie_q;
    acc_set    = 1'b0;
    pv_set     = 1'b0;
    launch     = 1'b0;
    if (wr_cfg) begin
      cbeie_d = reg_wdata[flash_seq_pkg::CBEIE_BIT];
      ccie_d  = reg_wdata[flash_seq_pkg::CCIE_BIT];
    end
    // R3 - host write order
    case (front_q)
      flash_seq_pkg::F_IDLE: begin
        if (prog_wr) begin
          // Array write while buffer-empty is clear or flagged poisons the sequence
          if (!bempty_q || aerr_q || pviol_q) begin
            acc_set = 1'b1;
          end else begin
            // R24 - latch address pair
            entry_d.addr = prog_addr;
            entry_d.data = prog_wdata;
            front_d      = flash_seq_pkg::F_WORD;
          end
        end else if (wr_stat && reg_wdata[flash_seq_pkg::BEMPTY_BIT]) begin
          // R6 - launch without sequence
          acc_set = 1'b1;
        end
      end
      flash_seq_pkg::F_WORD: begin
        if (wr_cmd && !prog_wr &&
            flash_seq_pkg::cmd_valid(reg_wdata[flash_seq_pkg::CMD_MSB:0])) begin
          entry_d.cmd = reg_wdata[flash_seq_pkg::CMD_MSB:0];
          front_d     = flash_seq_pkg::F_CMD;
        end else if (prog_wr || reg_wr) begin
          // R20 - bad code aborts
          acc_set = 1'b1;
          front_d = flash_seq_pkg::F_IDLE;
        end
      end
      flash_seq_pkg::F_CMD: begin
        if (prog_wr || (reg_wr && !wr_stat)) begin
          acc_set = 1'b1;
          front_d = flash_seq_pkg::F_IDLE;
        end else if (wr_stat) begin
          front_d = flash_seq_pkg::F_IDLE;
          if (!reg_wdata[flash_seq_pkg::BEMPTY_BIT]) begin
            acc_set = 1'b1;
          // R5 - no signature overlap
          end else if (flash_seq_pkg::is_sig(entry_q.cmd) &&
                       (exec_q != flash_seq_pkg::E_IDLE || buf_full_q)) begin
            acc_set = 1'b1;
          // R15 - protected target
          end else if (prot_hit) begin
            pv_set = 1'b1;
          end else begin
            launch = 1'b1;
          end
        end
      end
      default: front_d = flash_seq_pkg::F_IDLE;
    endcase
    if (wr_stat) begin
      if (reg_wdata[flash_seq_pkg::AERR_BIT]) aerr_d = 1'b0;
      if (reg_wdata[flash_seq_pkg::PVIOL_BIT])  pviol_d  = 1'b0;
      if (reg_wdata[flash_seq_pkg::BLANK_BIT])  blank_d  = 1'b0;
    end
    // R4 - second stage frees buffer
    if (xfer) begin
      buf_full_d = 1'b0;
      blank_d    = 1'b0;
      if (!flash_seq_pkg::is_sig(buf_q.cmd)) bempty_d = 1'b1;
    end
    // R22 - completion flag
    if (exec_done) begin
      if (!buf_full_q) cdone_d = 1'b1;
      if (flash_seq_pkg::is_sig(ex_q.cmd)) bempty_d = 1'b1;
    end
    // R12 - blank on clean verify
    if (blank_ok) blank_d = 1'b1;
    if (boot_done) begin
      bempty_d = 1'b1;
      cdone_d  = 1'b1;
    end
    // R21 - launch clears flags
    if (launch) begin
      buf_d      = entry_q;
      buf_full_d = 1'b1;
      bempty_d   = 1'b0;
      cdone_d    = 1'b0;
    end
    // Set beats a same-cycle clear
    if (acc_set) aerr_d = 1'b1;
    if (pv_set)  pviol_d  = 1'b1;
  end

  // R7 - interrupt enables
  assign irq_d = (cbeie_q && bempty_q) || (ccie_q && cdone_q);

  // Unmapped offsets read zero
  always_comb begin
    rdata_d = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        flash_seq_pkg::STAT_OFS:  rdata_d = {8'h00, bempty_q, cdone_q, pviol_q, aerr_q,
                                             1'b0, blank_q, 2'b00};
        flash_seq_pkg::CMD_OFS:   rdata_d = {9'h000, entry_q.cmd};
        flash_seq_pkg::DATA_OFS:  rdata_d = data_q;
        // R19 - trim low bits
        flash_seq_pkg::TRIM_OFS:  rdata_d = {6'h00, trim_q};
        flash_seq_pkg::FSIG_OFS:  rdata_d = fsig_q;
        flash_seq_pkg::CFG_OFS:   rdata_d = {8'h00, cbeie_q, ccie_q, 6'h00};
        default:                  rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      front_q    <= flash_seq_pkg::F_IDLE;
      entry_q    <= '0;
      buf_q      <= '0;
      buf_full_q <= 1'b0;
      bempty_q   <= 1'b0;
      cdone_q    <= 1'b0;
      aerr_q     <= 1'b0;
      pviol_q    <= 1'b0;
      blank_q    <= 1'b0;
      cbeie_q    <= 1'b0;
      ccie_q     <= 1'b0;
      irq        <= 1'b0;
      reg_rdata  <= 16'h0000;
    end else begin
      front_q    <= front_d;
      entry_q    <= entry_d;
      buf_q      <= buf_d;
      buf_full_q <= buf_full_d;
      bempty_q   <= bempty_d;
      cdone_q    <= cdone_d;
      aerr_q     <= aerr_d;
      pviol_q    <= pviol_d;
      blank_q    <= blank_d;
      cbeie_q    <= cbeie_d;
      ccie_q     <= ccie_d;
      irq        <= irq_d;
      reg_rdata  <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Command engine; boots by fetching trim and factory signature
  // ----------------------------------------------------------------
  always_comb begin
    exec_d    = exec_q;
    ex_d      = ex_q;
    ptr_d     = ptr_q;
    rem_d     = rem_q;
    rvalid_d  = 1'b0;
    allone_d  = allone_q;
    data_d    = data_q;
    trim_d    = trim_q;
    fsig_d    = fsig_q;
    misr_clr  = 1'b0;
    wr_en     = 1'b0;
    wr_data   = flash_seq_pkg::ERASED;
    exec_done = 1'b0;
    boot_done = 1'b0;
    if (rvalid_q && (seq_rdata != flash_seq_pkg::ERASED)) allone_d = 1'b0;
    case (exec_q)
      flash_seq_pkg::E_BOOT_TRIM: begin
        ptr_d  = flash_seq_pkg::SIG_IDX;
        exec_d = flash_seq_pkg::E_BOOT_SIG;
      end
      flash_seq_pkg::E_BOOT_SIG: begin
        trim_d = seq_rdata[flash_seq_pkg::TRIM_MSB:0];
        exec_d = flash_seq_pkg::E_BOOT_CAP;
      end
      flash_seq_pkg::E_BOOT_CAP: begin
        // R18 - factory signature load
        fsig_d    = seq_rdata;
        boot_done = 1'b1;
        exec_d    = flash_seq_pkg::E_IDLE;
      end
      flash_seq_pkg::E_IDLE: begin
        if (xfer) begin
          ex_d     = buf_q;
          misr_clr = 1'b1;
          allone_d = 1'b1;
          case (buf_q.cmd)
            flash_seq_pkg::CMD_PROGRAM: begin
              ptr_d  = {1'b0, buf_q.addr};
              exec_d = flash_seq_pkg::E_PROG_RD;
            end
            // R10 - whole page
            flash_seq_pkg::CMD_PAGE_ERASE: begin
              ptr_d  = {1'b0, buf_q.addr & flash_seq_pkg::PAGE_MASK};
              rem_d  = flash_seq_pkg::PAGE_WORDS;
              exec_d = flash_seq_pkg::E_ERASE;
            end
            // R11 - whole array
            flash_seq_pkg::CMD_MASS_ERASE: begin
              ptr_d  = flash_seq_pkg::ARRAY_BASE;
              rem_d  = flash_seq_pkg::ARRAY_WORDS;
              exec_d = flash_seq_pkg::E_ERASE;
            end
            flash_seq_pkg::CMD_VERIFY: begin
              ptr_d  = flash_seq_pkg::ARRAY_BASE;
              rem_d  = flash_seq_pkg::ARRAY_WORDS;
              exec_d = flash_seq_pkg::E_SCAN;
            end
            // R13 - zero length runs full counter
            flash_seq_pkg::CMD_DATA_SIG: begin
              ptr_d  = {1'b0, buf_q.addr};
              rem_d  = (buf_q.data == 16'h0000) ? flash_seq_pkg::MAX_LEN : {1'b0, buf_q.data};
              exec_d = flash_seq_pkg::E_SCAN;
            end
            // R17 - info row less last word
            default: begin
              ptr_d  = flash_seq_pkg::INFO_BASE;
              rem_d  = flash_seq_pkg::INFO_SIG_WORDS;
              exec_d = flash_seq_pkg::E_SCAN;
            end
          endcase
        end
      end
      flash_seq_pkg::E_PROG_RD: exec_d = flash_seq_pkg::E_PROG_WR;
      flash_seq_pkg::E_PROG_WR: begin
        // R8 - only clears bits
        wr_en     = 1'b1;
        wr_data   = seq_rdata & ex_q.data;
        exec_done = 1'b1;
        exec_d    = flash_seq_pkg::E_IDLE;
      end
      flash_seq_pkg::E_ERASE: begin
        wr_en = 1'b1;
        ptr_d = {ptr_q[8], ptr_q[7:0] + flash_seq_pkg::ADDR_STEP};
        rem_d = rem_q - flash_seq_pkg::REM_STEP;
        if (rem_q == flash_seq_pkg::REM_STEP) begin
          exec_done = 1'b1;
          exec_d    = flash_seq_pkg::E_IDLE;
        end
      end
      flash_seq_pkg::E_SCAN: begin
        // Address wraps inside the region it started in
        if (rem_q != '0) begin
          ptr_d    = {ptr_q[8], ptr_q[7:0] + flash_seq_pkg::ADDR_STEP};
          rem_d    = rem_q - flash_seq_pkg::REM_STEP;
          rvalid_d = 1'b1;
        end else if (!rvalid_q) begin
          exec_done = 1'b1;
          // R23 - result only on signature end
          if (flash_seq_pkg::is_sig(ex_q.cmd)) data_d = misr_sig;
          exec_d = flash_seq_pkg::E_IDLE;
        end
      end
      default: exec_d = flash_seq_pkg::E_IDLE;
    endcase
  end

  assign blank_ok = exec_done && (ex_q.cmd == flash_seq_pkg::CMD_VERIFY) && allone_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      exec_q   <= flash_seq_pkg::E_BOOT_TRIM;
      ex_q     <= '0;
      ptr_q    <= flash_seq_pkg::TRIM_IDX;
      rem_q    <= '0;
      rvalid_q <= 1'b0;
      allone_q <= 1'b0;
      data_q   <= 16'h0000;
      trim_q   <= '0;
      fsig_q   <= 16'h0000;
    end else begin
      exec_q   <= exec_d;
      ex_q     <= ex_d;
      ptr_q    <= ptr_d;
      rem_q    <= rem_d;
      rvalid_q <= rvalid_d;
      allone_q <= allone_d;
      data_q   <= data_d;
      trim_q   <= trim_d;
      fsig_q   <= fsig_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  launch_clears_a: assert property (launch |=> !cdone_q && !bempty_q && buf_full_q) // R21
    else $error("launch did not clear flags");
  bad_code_a: assert property (front_q == flash_seq_pkg::F_WORD && wr_cmd && !prog_wr && // R20
      !flash_seq_pkg::cmd_valid(reg_wdata[flash_seq_pkg::CMD_MSB:0])
      |=> aerr_q && front_q == flash_seq_pkg::F_IDLE)
    else $error("invalid command not flagged");
  early_launch_a: assert property (front_q == flash_seq_pkg::F_IDLE && !prog_wr && wr_stat && // R6
      reg_wdata[flash_seq_pkg::BEMPTY_BIT] |=> aerr_q && !buf_full_q)
    else $error("launch without sequence accepted");
  sig_block_a: assert property (exec_q == flash_seq_pkg::E_SCAN && // R5
      flash_seq_pkg::is_sig(ex_q.cmd) |-> !bempty_q && !buf_full_q)
    else $error("queue open during signature");
  prot_prog_a: assert property (front_q == flash_seq_pkg::F_CMD && wr_stat && !prog_wr && // R14
      reg_wdata[flash_seq_pkg::BEMPTY_BIT] && !aerr_q && prot_hit &&
      !flash_seq_pkg::is_sig(entry_q.cmd) |=> pviol_q && !buf_full_q)
    else $error("protected command launched");
  page_bound_a: assert property (exec_q == flash_seq_pkg::E_ERASE && // R10
      ex_q.cmd == flash_seq_pkg::CMD_PAGE_ERASE
      |-> (ptr_q[7:0] & flash_seq_pkg::PAGE_MASK) == (ex_q.addr & flash_seq_pkg::PAGE_MASK))
    else $error("page erase left its page");
  data_hold_a: assert property (!(exec_done && flash_seq_pkg::is_sig(ex_q.cmd)) // R23
      |=> $stable(data_q))
    else $error("signature result changed");
  done_flag_a: assert property (exec_done && !buf_full_q && !launch |=> cdone_q) // R22
    else $error("completion not flagged");
  blank_cause_a: assert property ($rose(blank_q) |-> $past(blank_ok)) // R12
    else $error("blank set without clean verify");
  one_word_a: assert property (front_q == flash_seq_pkg::F_WORD && prog_wr // R24
      |=> aerr_q && front_q == flash_seq_pkg::F_IDLE)
    else $error("second array write accepted");

endmodule : flash_cmd_seq

// >>> rtl/flash_seq_pkg.sv
// Constants, command codes, state encodings and carriers for the flash
// command sequencer. Assumes 16-bit words and word-addressed register space.
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          AW         = 8;
  localparam int          MEM_AW     = 9;
  localparam int          DW         = 16;
  localparam int          PAGE_BITS  = 5;
  localparam int          MEM_WORDS  = 272;
  localparam int          REM_W      = 17;
  localparam logic [7:0]  PAGE_MASK  = 8'he0;
  localparam logic [7:0]  ADDR_STEP  = 8'h01;
  localparam logic [8:0]  ARRAY_BASE = 9'h000;
  localparam logic [8:0]  INFO_BASE  = 9'h100;
  localparam logic [8:0]  TRIM_IDX   = 9'h100;
  localparam logic [8:0]  SIG_IDX    = 9'h10f;
  localparam logic [16:0] PAGE_WORDS = 17'h00020;
  localparam logic [16:0] ARRAY_WORDS = 17'h00100;
  localparam logic [16:0] INFO_SIG_WORDS = 17'h0000f;
  localparam logic [16:0] MAX_LEN    = 17'h10000;
  localparam logic [16:0] REM_STEP   = 17'h00001;
  localparam logic [15:0] ERASED     = 16'hffff;
  localparam logic [15:0] MISR_POLY  = 16'h8016;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_OFS    = 8'h03;
  localparam logic [7:0]  STAT_OFS   = 8'h13;
  localparam logic [7:0]  CMD_OFS    = 8'h14;
  localparam logic [7:0]  DATA_OFS   = 8'h18;
  localparam logic [7:0]  TRIM_OFS   = 8'h1a;
  localparam logic [7:0]  FSIG_OFS   = 8'h1b;
  localparam int          BEMPTY_BIT = 7;
  localparam int          CDONE_BIT  = 6;
  localparam int          PVIOL_BIT  = 5;
  localparam int          AERR_BIT   = 4;
  localparam int          BLANK_BIT  = 2;
  localparam int          CBEIE_BIT  = 7;
  localparam int          CCIE_BIT   = 6;
  localparam int          CMD_MSB    = 6;
  localparam int          TRIM_MSB   = 9;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [6:0]  CMD_VERIFY     = 7'h05;
  localparam logic [6:0]  CMD_DATA_SIG   = 7'h06;
  localparam logic [6:0]  CMD_PROGRAM    = 7'h20;
  localparam logic [6:0]  CMD_PAGE_ERASE = 7'h40;
  localparam logic [6:0]  CMD_MASS_ERASE = 7'h41;
  localparam logic [6:0]  CMD_INFO_SIG   = 7'h66;

  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_WORD = 2'b01,
    F_CMD  = 2'b10
  } front_state_t;

  typedef enum logic [2:0] {
    E_BOOT_TRIM = 3'b000,
    E_BOOT_SIG  = 3'b001,
    E_BOOT_CAP  = 3'b010,
    E_IDLE      = 3'b011,
    E_PROG_RD   = 3'b100,
    E_PROG_WR   = 3'b101,
    E_ERASE     = 3'b110,
    E_SCAN      = 3'b111
  } exec_state_t;

  typedef struct packed {
    logic [6:0]  cmd;
    logic [7:0]  addr;
    logic [15:0] data;
  } cmd_entry_t;

  function automatic logic is_sig(input logic [6:0] c);
    is_sig = (c == CMD_DATA_SIG) || (c == CMD_INFO_SIG);
  endfunction : is_sig

  function automatic logic cmd_valid(input logic [6:0] c);
    cmd_valid = (c == CMD_VERIFY) || (c == CMD_DATA_SIG) || (c == CMD_PROGRAM) ||
                (c == CMD_PAGE_ERASE) || (c == CMD_MASS_ERASE) || (c == CMD_INFO_SIG);
  endfunction : cmd_valid

endpackage : flash_seq_pkg

// >>> rtl/sig_misr.sv
// Multiple-input signature register for the signature commands.
// Assumes the caller clears it before each new signature.
`timescale 1ns/1ps
module sig_misr (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [15:0] din,
  output logic      [15:0] sig_q
);
  logic [15:0] sig_d;

  always_comb begin
    sig_d = sig_q;
    if (clr) begin
      sig_d = '0;
    end else if (en) begin
      sig_d = {sig_q[14:0], 1'b0} ^ (sig_q[15] ? flash_seq_pkg::MISR_POLY : '0) ^ din;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sig_q <= '0;
    end else begin
      sig_q <= sig_d;
    end
  end
endmodule : sig_misr

// >>> tb/host_model.sv
// Host core model: program-bus and data-bus master for the sequencer.
// Assumes one-cycle strobes, driven 1 ns after the rising edge.
`timescale 1ns/1ps
module host_model (
  input  wire logic        ref_clk,
  output logic      [7:0]  prog_addr,
  output logic             prog_wr,
  output logic      [15:0] prog_wdata,
  input  wire logic [15:0] prog_rdata,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    {prog_addr, prog_wr, prog_wdata} = '0;
    {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  end
  // Released data lines flip so stale values never look valid
  task automatic wr(input logic arr, input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    {prog_addr, reg_addr, prog_wdata, reg_wdata} = {a, a, d, d};
    {prog_wr, reg_wr} = {arr, !arr};
    @(posedge ref_clk);
    #1;
    {prog_wr, reg_wr} = 2'b00;
    {prog_wdata, reg_wdata} = {~d, ~d};
  endtask : wr
  task automatic rd(input logic arr, input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    {prog_addr, reg_addr} = {a, a};
    reg_rd = !arr;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    d = arr ? prog_rdata : reg_rdata;
  endtask : rd
  task automatic launch(input logic [6:0] c, input logic [7:0] a, input logic [15:0] d);
    wr(1'b1, a, d);
    wr(1'b0, flash_seq_pkg::CMD_OFS, {9'h000, c});
    wr(1'b0, flash_seq_pkg::STAT_OFS, 16'h0080);
  endtask : launch
endmodule : host_model

// >>> tb/tb_flash_cmd_seq.sv
// Self-checking bench for the flash command sequencer.
// Assumes the host model is the only bus master; protection set here.
`timescale 1ns/1ps
module tb_flash_cmd_seq;
  logic        ref_clk, rstn, prog_wr, reg_wr, reg_rd, irq;
  logic [7:0]  prog_addr, reg_addr, sector_protect;
  logic [15:0] prog_wdata, prog_rdata, reg_wdata, reg_rdata, v;
  int          mismatches, compares;
  host_model i_host_model (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_wr(prog_wr),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  flash_cmd_seq i_flash_cmd_seq (.ref_clk(ref_clk), .rstn(rstn), .prog_addr(prog_addr),
    .prog_wr(prog_wr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sector_protect(sector_protect), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Bounded poll on the completion flag
  task automatic done_rd(input logic arr, input logic [7:0] a);
    logic seen;
    seen = 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 400 && !seen; i++) begin
      i_host_model.rd(1'b0, flash_seq_pkg::STAT_OFS, v);
      seen = (v[flash_seq_pkg::CDONE_BIT] === 1'b1);
    end
    // Poll limit running out is a failure
    if (!seen) mismatches++;
    i_host_model.rd(arr, a, v);
  endtask : done_rd
  // Signature of n erased words, worked out independently
  function automatic logic [15:0] misr(input int n);
    misr = 16'h0000;
    for (int i = 0; i < n; i++)
      misr = {misr[14:0], 1'b0} ^ (misr[15] ? 16'h8016 : 16'h0000) ^ 16'hffff;
  endfunction : misr
  initial begin
    {mismatches, compares, rstn, sector_protect} = '0;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (5) @(posedge ref_clk);
    i_host_model.rd(1'b0, 8'h1a, v);
    chk(v, 16'h03ff);
    i_host_model.rd(1'b0, 8'h1b, v);
    chk(v, 16'hffff);
    i_host_model.launch(flash_seq_pkg::CMD_PROGRAM, 8'h25, 16'h1234);
    done_rd(1'b1, 8'h25);
    chk(v, 16'h1234);
    i_host_model.wr(1'b0, flash_seq_pkg::CFG_OFS, 16'h0040);
    @(posedge ref_clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    i_host_model.launch(flash_seq_pkg::CMD_PROGRAM, 8'h25, 16'hff0f);
    done_rd(1'b1, 8'h25);
    chk(v, 16'h1204);
    sector_protect = 8'h02;
    for (int k = 0; k < 2; k++) begin
      i_host_model.launch(k ? 7'h41 : 7'h40, 8'h3f, 16'h0000);
      done_rd(1'b0, flash_seq_pkg::STAT_OFS);
      chk(v, 16'h00e0);
      i_host_model.wr(1'b0, flash_seq_pkg::STAT_OFS, 16'h0020);
    end
    sector_protect = 8'h00;
    i_host_model.launch(flash_seq_pkg::CMD_PAGE_ERASE, 8'h3f, 16'h1234);
    @(posedge ref_clk);
    i_host_model.launch(flash_seq_pkg::CMD_PROGRAM, 8'h44, 16'h5a5a);
    done_rd(1'b1, 8'h44);
    chk(v, 16'h5a5a);
    i_host_model.rd(1'b1, 8'h25, v);
    chk(v, 16'hffff);
    i_host_model.launch(flash_seq_pkg::CMD_VERIFY, 8'h10, 16'h0000);
    done_rd(1'b0, 8'h13);
    chk(v, 16'h00c0);
    i_host_model.launch(flash_seq_pkg::CMD_MASS_ERASE, 8'h80, 16'h0000);
    done_rd(1'b1, 8'h44);
    chk(v, 16'hffff);
    i_host_model.launch(flash_seq_pkg::CMD_VERIFY, 8'hf0, 16'h0000);
    done_rd(1'b0, 8'h13);
    chk(v, 16'h00c4);
    i_host_model.launch(flash_seq_pkg::CMD_INFO_SIG, 8'h10, 16'h0003);
    done_rd(1'b0, 8'h18);
    chk(v, misr(15));
    i_host_model.launch(flash_seq_pkg::CMD_DATA_SIG, 8'h10, 16'h0003);
    done_rd(1'b0, 8'h18);
    chk(v, misr(3));
    i_host_model.launch(flash_seq_pkg::CMD_PROGRAM, 8'h01, 16'h0000);
    done_rd(1'b0, 8'h18);
    chk(v, misr(3));
    i_host_model.launch(7'h07, 8'h10, 16'h0000);
    done_rd(1'b0, 8'h13);
    chk(v, 16'h00d0);
    wrap_up();
  end
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule : tb_flash_cmd_seq
